/* File: src/phy_status_cfg.svh */
`ifndef PHY_STATUS_CFG_SVH
`define PHY_STATUS_CFG_SVH

// Register indices; the byte address is four times the index.
`define IDX_BASIC_MODE_STATUS    6'h01
`define IDX_AUTONEG_EXPANSION    6'h06
`define IDX_PHY_STATUS_SUMMARY   6'h10
`define IDX_INTERRUPT_SOURCE     6'h12
`define IDX_EVENT_STATUS         6'h20
`define IDX_EVENT_MASK           6'h21

// Field positions in the summary status register.
`define SUM_PAGE_RX_BIT          8
`define SUM_IRQ_PEND_BIT         7
`define SUM_REMOTE_FAULT_BIT     6
`define SUM_JABBER_BIT           5
`define SUM_AN_DONE_BIT          4
`define SUM_LOOPBACK_BIT         3
`define SUM_FULL_DUPLEX_BIT      2

// Page-received position in the expansion view.
`define ANEG_PAGE_RX_BIT         1

// Positions of the sticky flags and of the event status and mask bits.
`define FLAG_PAGE                0
`define FLAG_PEND                1
`define FLAG_FAULT               2
`define FLAG_COUNT               3

// Reset values.
`define SUMMARY_RST              16'h0000
`define FLAGS_RST                3'h0
`define MASK_RST                 3'h0
`define RDATA_RST                32'h0000_0000

// Bus responses.
`define RESP_OKAY                2'h0
`define RESP_SLVERR              2'h2

`endif

/* File: src/phy_status_pkg.sv */
/*
  Types shared by the summary status block and its flag store.
  Assumes the constants header is on the include path.
*/
`include "phy_status_cfg.svh"

package phy_status_pkg;

  // Inputs from the logic that owns the source registers.
  typedef struct packed {
    logic page_rx;
    logic irq_event;
    logic remote_fault;
    logic jabber;
    logic an_done;
    logic loopback;
    logic full_duplex;
    logic link_up;
  } phy_src_t;

  // Read strobes towards the owners of the source registers.
  typedef struct packed {
    logic aneg_rd;
    logic int_src_rd;
    logic basic_rd;
  } src_read_t;

  typedef logic [`FLAG_COUNT-1:0] flags_t;

  function automatic logic [7:0] reg_addr(input logic [5:0] idx);
    return {idx, 2'b00};
  endfunction : reg_addr

endpackage : phy_status_pkg

/* File: src/sticky_flags.sv */
/*
  A set of sticky flags where a set in the same cycle as a clear wins.
  Assumes set and clear come from logic on the same clock.
*/
`timescale 1ns/1ps
`include "phy_status_cfg.svh"

module sticky_flags
  import phy_status_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   rst_n,
  input  wire flags_t set,
  input  wire flags_t clr,
  output flags_t      q
);

  flags_t next_q;

  always_comb begin
    next_q = (q & ~clr) | set;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= `FLAGS_RST;
    end else begin
      q <= next_q;
    end
  end

endmodule : sticky_flags

/* File: src/phy_status_summary.sv */
/*
  Summary status register of the transceiver behind an AXI4-Lite slave,
  with sticky event status, mask and one interrupt output.
  Assumes source inputs come from logic on CLK and that the master keeps
  one write and one read under way at a time.
*/
// Implementation choice: register access over AXI4-Lite.
// Contract
// - Bit 8 mirrors page received flag.
// - Page flag clears only on expansion read.
// - Bit 7 shows any pending internal interrupt.
// - Interrupt source read clears pending bit.
// - Bit 6 sets on partner remote fault.
// - Fault holds until basic status read, reset.
// - Bit 5 reports jabber, meaningful at 10 Mb/s.
// - Jabber mirrors basic status, summary read keeps.
// - Bit 4 shows auto-negotiation complete.
// - Bit 3 shows interface loopback active.
// - Bit 2 reads one in full duplex with link up.
// - Bit 2 zero in half duplex, link up.
// - Register at 0x0040 (index 0x10), read-only, resets zero; bits 5:2 mirror SRC, not reset.
`timescale 1ns/1ps
`include "phy_status_cfg.svh"

module phy_status_summary
  import phy_status_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire phy_src_t    SRC,
  output src_read_t        SRC_RD,
  output logic             IRQ,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY
);

  // Write channel state.
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        next_aw_held;
  logic        next_w_held;
  logic [7:0]  next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0]  next_w_strb;
  logic [1:0]  next_bresp;
  logic        next_bvalid;
  logic        wr_fire;

  // Read channel state.
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic        next_rvalid;
  logic        rd_fire;

  // Mask and derived values.
  flags_t      mask;
  flags_t      next_mask;
  flags_t      flags;
  flags_t      flag_set;
  flags_t      flag_clr;
  flags_t      evt_status;
  flags_t      evt_set;
  flags_t      evt_clr;
  logic [15:0] summary;

  assign AWREADY = !aw_held && !BVALID;
  assign WREADY  = !w_held && !BVALID;
  assign ARREADY = !RVALID;
  assign rd_fire = ARVALID && ARREADY;

  // Reads of the source registers clear the copies at the same edge.
  assign SRC_RD.aneg_rd    = rd_fire && (ARADDR == reg_addr(`IDX_AUTONEG_EXPANSION));
  assign SRC_RD.int_src_rd = rd_fire && (ARADDR == reg_addr(`IDX_INTERRUPT_SOURCE));
  assign SRC_RD.basic_rd   = rd_fire && (ARADDR == reg_addr(`IDX_BASIC_MODE_STATUS));

  always_comb begin
    flag_set = '0;
    flag_clr = '0;
    flag_set[`FLAG_PAGE]  = SRC.page_rx;
    flag_clr[`FLAG_PAGE]  = SRC_RD.aneg_rd;
    flag_set[`FLAG_PEND]  = SRC.irq_event;
    flag_clr[`FLAG_PEND]  = SRC_RD.int_src_rd;
    flag_set[`FLAG_FAULT] = SRC.remote_fault;
    flag_clr[`FLAG_FAULT] = SRC_RD.basic_rd;
  end

  sticky_flags u_summary_flags (
    .clk   (CLK),
    .rst_n (RST_N),
    .set   (flag_set),
    .clr   (flag_clr),
    .q     (flags)
  );

  always_comb begin
    evt_set = flag_set;
    evt_clr = '0;
    if (wr_fire && (aw_addr == reg_addr(`IDX_EVENT_STATUS)) && w_strb[0]) begin
      evt_clr = w_data[`FLAG_COUNT-1:0];
    end
  end

  sticky_flags u_event_status (
    .clk   (CLK),
    .rst_n (RST_N),
    .set   (evt_set),
    .clr   (evt_clr),
    .q     (evt_status)
  );

  assign IRQ = |(evt_status & mask);

  always_comb begin
    summary = `SUMMARY_RST;
    summary[`SUM_PAGE_RX_BIT]      = flags[`FLAG_PAGE];
    summary[`SUM_IRQ_PEND_BIT]     = flags[`FLAG_PEND];
    summary[`SUM_REMOTE_FAULT_BIT] = flags[`FLAG_FAULT];
    summary[`SUM_JABBER_BIT]       = SRC.jabber;
    summary[`SUM_AN_DONE_BIT]      = SRC.an_done;
    summary[`SUM_LOOPBACK_BIT]     = SRC.loopback;
    summary[`SUM_FULL_DUPLEX_BIT]  = SRC.full_duplex && SRC.link_up;
  end

  // Write path: address and data are taken in either order.
  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = BVALID;
    next_bresp   = BRESP;
    next_mask    = mask;
    wr_fire      = aw_held && w_held && !BVALID;
    if (AWVALID && AWREADY) begin
      next_aw_held = 1'b1;
      next_aw_addr = AWADDR;
    end
    if (WVALID && WREADY) begin
      next_w_held = 1'b1;
      next_w_data = WDATA;
      next_w_strb = WSTRB;
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = `RESP_OKAY;
      if (aw_addr == reg_addr(`IDX_EVENT_MASK)) begin
        if (w_strb[0]) begin
          next_mask = w_data[`FLAG_COUNT-1:0];
        end
      end else if (aw_addr == reg_addr(`IDX_PHY_STATUS_SUMMARY)) begin
        next_bresp = `RESP_OKAY;
      end else if (aw_addr == reg_addr(`IDX_EVENT_STATUS)) begin
        next_bresp = `RESP_OKAY;
      end else if (aw_addr == reg_addr(`IDX_AUTONEG_EXPANSION) ||
                   aw_addr == reg_addr(`IDX_INTERRUPT_SOURCE) ||
                   aw_addr == reg_addr(`IDX_BASIC_MODE_STATUS)) begin
        next_bresp = `RESP_OKAY;
      end else begin
        next_bresp = `RESP_SLVERR;
      end
    end else if (BVALID && BREADY) begin
      next_bvalid = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= `RDATA_RST;
      w_strb  <= 4'h0;
      BVALID  <= 1'b0;
      BRESP   <= `RESP_OKAY;
      mask    <= `MASK_RST;
    end else begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      BVALID  <= next_bvalid;
      BRESP   <= next_bresp;
      mask    <= next_mask;
    end
  end

  // Read path: data are captured before the read-side clear takes effect.
  always_comb begin
    next_rdata  = RDATA;
    next_rresp  = RRESP;
    next_rvalid = RVALID;
    if (rd_fire) begin
      next_rvalid = 1'b1;
      next_rresp  = `RESP_OKAY;
      next_rdata  = `RDATA_RST;
      if (ARADDR == reg_addr(`IDX_PHY_STATUS_SUMMARY)) begin
        next_rdata[15:0] = summary;
      end else if (ARADDR == reg_addr(`IDX_AUTONEG_EXPANSION)) begin
        next_rdata[`ANEG_PAGE_RX_BIT] = flags[`FLAG_PAGE];
      end else if (ARADDR == reg_addr(`IDX_INTERRUPT_SOURCE)) begin
        next_rdata = `RDATA_RST;
      end else if (ARADDR == reg_addr(`IDX_BASIC_MODE_STATUS)) begin
        next_rdata = `RDATA_RST;
      end else if (ARADDR == reg_addr(`IDX_EVENT_STATUS)) begin
        next_rdata[`FLAG_COUNT-1:0] = evt_status;
      end else if (ARADDR == reg_addr(`IDX_EVENT_MASK)) begin
        next_rdata[`FLAG_COUNT-1:0] = mask;
      end else begin
        next_rresp = `RESP_SLVERR;
      end
    end else if (RVALID && RREADY) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA  <= `RDATA_RST;
      RRESP  <= `RESP_OKAY;
      RVALID <= 1'b0;
    end else begin
      RDATA  <= next_rdata;
      RRESP  <= next_rresp;
      RVALID <= next_rvalid;
    end
  end

  logic sum_rd;
  assign sum_rd = rd_fire && (ARADDR == reg_addr(`IDX_PHY_STATUS_SUMMARY));

  a_page_set: assert property (
    @(posedge CLK) disable iff (!RST_N)
    SRC.page_rx |=> flags[`FLAG_PAGE])
    else $error("Page flag did not follow page event.");

  a_page_kept: assert property (
    @(posedge CLK) disable iff (!RST_N)
    (flags[`FLAG_PAGE] && !SRC_RD.aneg_rd) |=> flags[`FLAG_PAGE])
    else $error("Page flag lost without expansion read.");

  a_page_cleared: assert property (
    @(posedge CLK) disable iff (!RST_N)
    (SRC_RD.aneg_rd && !SRC.page_rx) |=> !flags[`FLAG_PAGE])
    else $error("Page flag survived expansion read.");

  a_pend_shown: assert property (
    @(posedge CLK) disable iff (!RST_N)
    sum_rd |=> RDATA[`SUM_IRQ_PEND_BIT] == $past(flags[`FLAG_PEND]))
    else $error("Pending interrupt not shown in summary.");

  a_pend_cleared: assert property (
    @(posedge CLK) disable iff (!RST_N)
    (SRC_RD.int_src_rd && !SRC.irq_event) |=> !flags[`FLAG_PEND])
    else $error("Pending bit survived interrupt source read.");

  a_fault_held: assert property (
    @(posedge CLK) disable iff (!RST_N)
    (flags[`FLAG_FAULT] && !SRC_RD.basic_rd) |=> $stable(flags[`FLAG_FAULT]))
    else $error("Remote fault dropped without basic status read.");

  a_fault_set: assert property (
    @(posedge CLK) disable iff (!RST_N)
    SRC.remote_fault |=> flags[`FLAG_FAULT])
    else $error("Remote fault not latched.");

  a_level_bits: assert property (
    @(posedge CLK) disable iff (!RST_N)
    sum_rd |=> (RDATA[`SUM_AN_DONE_BIT] == $past(SRC.an_done)) &&
               (RDATA[`SUM_LOOPBACK_BIT] == $past(SRC.loopback)) &&
               (RDATA[`SUM_JABBER_BIT] == $past(SRC.jabber)))
    else $error("Level status bits not reported on read.");

  a_duplex_bit: assert property (
    @(posedge CLK) disable iff (!RST_N)
    sum_rd |=> RDATA[`SUM_FULL_DUPLEX_BIT] == $past(SRC.full_duplex && SRC.link_up))
    else $error("Duplex bit wrong on read.");

  a_reserved_zero: assert property (
    @(posedge CLK) disable iff (!RST_N)
    sum_rd |=> (RDATA[31:9] == 23'h000000) && (RDATA[1:0] == 2'h0))
    else $error("Out of range summary bits not zero.");

  a_write_inert: assert property (
    @(posedge CLK) disable iff (!RST_N)
    (wr_fire && aw_addr == reg_addr(`IDX_PHY_STATUS_SUMMARY) && flag_set == '0 &&
     flag_clr == '0) |=> $stable(flags) && $stable(mask))
    else $error("Summary write changed state.");

endmodule : phy_status_summary

/* File: dv/phy_status_summary_bench.sv */
/*
  Self-checking bench for the summary status block: bus tasks, a flag model and checks.
  Assumes the package and the constants header are compiled before this file.
*/
`timescale 1ns/1ps
`include "phy_status_cfg.svh"

module phy_status_summary_bench
  import phy_status_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  phy_src_t    src = '0;
  src_read_t   src_rd;
  logic        irq, awready, wready, bvalid, arready, rvalid;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'h0;
  logic [1:0]  bresp, rresp;
  logic [31:0] seed = 32'h44;
  int          n_errors = 0, n_compared = 0;
  logic        pg = 1'b0, pd = 1'b0, ft = 1'b0;
  logic [2:0]  ev = 3'h0, mk = 3'h0;

  phy_status_summary dut_u (
    .CLK(clk), .RST_N(rst_n), .SRC(src), .SRC_RD(src_rd), .IRQ(irq),
    .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready)
  );

  always #2 clk = ~clk;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic [31:0] sum_exp();
    return {23'h0, pg, pd, ft, src.jabber, src.an_done, src.loopback,
            src.full_duplex & src.link_up, 2'b00};
  endfunction : sum_exp

  task automatic tally_and_finish();
    if (n_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic hang();
    n_errors++;
    $display("CHECK FAILED at %0t: bus gave no answer", $time);
    tally_and_finish();
  endtask : hang

  // Bus write; the response code is compared with the expected one.
  task automatic wr(input logic [5:0] idx, input logic [31:0] d, input logic [1:0] er);
    awaddr  <= {idx, 2'b00};
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        cmp(32'(bresp), 32'(er));
        @(posedge clk);
        return;
      end
    end
    hang();
  endtask : wr

  // Bus read; checks the source read strobes, the data and the response.
  task automatic rc(input logic [5:0] idx, input logic [31:0] ed, input logic [1:0] er);
    src_read_t es;
    es.aneg_rd    = (idx == `IDX_AUTONEG_EXPANSION);
    es.int_src_rd = (idx == `IDX_INTERRUPT_SOURCE);
    es.basic_rd   = (idx == `IDX_BASIC_MODE_STATUS);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(posedge clk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        cmp(32'(src_rd), 32'(es));
      end
      if (rvalid) begin
        rready <= 1'b0;
        cmp(rdata, ed);
        cmp(32'(rresp), 32'(er));
        @(posedge clk);
        return;
      end
    end
    hang();
  endtask : rc

  // One-cycle event pulses: bit 0 page, bit 1 pending, bit 2 fault.
  task automatic pulse(input logic [2:0] p);
    src[7:5] <= {p[0], p[1], p[2]};
    @(posedge clk);
    src[7:5] <= 3'h0;
    @(posedge clk);
    {ft, pd, pg} = {ft, pd, pg} | p;
    ev = ev | p;
  endtask : pulse

  task automatic irq_chk();
    @(posedge clk);
    cmp(32'(irq), 32'(|(ev & mk)));
  endtask : irq_chk

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    {pg, pd, ft, ev, mk} = '0;
    @(posedge clk);
  endtask : do_reset

  initial begin
    logic [31:0] r;
    do_reset();
    rc(`IDX_PHY_STATUS_SUMMARY, 32'h0, `RESP_OKAY);
    rc(`IDX_EVENT_STATUS, 32'h0, `RESP_OKAY);
    rc(`IDX_EVENT_MASK, 32'h0, `RESP_OKAY);
    pulse(3'h7);
    rc(`IDX_PHY_STATUS_SUMMARY, sum_exp(), `RESP_OKAY);
    rc(`IDX_PHY_STATUS_SUMMARY, sum_exp(), `RESP_OKAY);
    rc(`IDX_AUTONEG_EXPANSION, {30'h0, pg, 1'b0}, `RESP_OKAY);
    pg = 1'b0;
    rc(`IDX_PHY_STATUS_SUMMARY, sum_exp(), `RESP_OKAY);
    rc(`IDX_INTERRUPT_SOURCE, 32'h0, `RESP_OKAY);
    pd = 1'b0;
    rc(`IDX_PHY_STATUS_SUMMARY, sum_exp(), `RESP_OKAY);
    rc(`IDX_BASIC_MODE_STATUS, 32'h0, `RESP_OKAY);
    ft = 1'b0;
    rc(`IDX_PHY_STATUS_SUMMARY, sum_exp(), `RESP_OKAY);
    for (int i = 0; i < 16; i++) begin
      r = xs();
      src[4:0] <= r[4:0];
      @(posedge clk);
      if (r[5]) pulse(r[8:6]);
      rc(`IDX_PHY_STATUS_SUMMARY, sum_exp(), `RESP_OKAY);
    end
    wr(`IDX_PHY_STATUS_SUMMARY, 32'hffff_ffff, `RESP_OKAY);
    rc(`IDX_PHY_STATUS_SUMMARY, sum_exp(), `RESP_OKAY);
    wr(6'h3f, 32'h0, `RESP_SLVERR);
    rc(6'h3f, 32'h0, `RESP_SLVERR);
    pulse(3'h7);
    rc(`IDX_EVENT_STATUS, 32'(ev), `RESP_OKAY);
    irq_chk();
    wr(`IDX_EVENT_MASK, 32'h2, `RESP_OKAY);
    mk = 3'h2;
    irq_chk();
    wr(`IDX_EVENT_STATUS, 32'h2, `RESP_OKAY);
    ev = ev & 3'h5;
    irq_chk();
    rc(`IDX_EVENT_STATUS, 32'(ev), `RESP_OKAY);
    rc(`IDX_EVENT_MASK, 32'h2, `RESP_OKAY);
    pulse(3'h4);
    do_reset();
    rc(`IDX_PHY_STATUS_SUMMARY, sum_exp(), `RESP_OKAY);
    tally_and_finish();
  end
endmodule : phy_status_summary_bench
